// *** core/evt_trig_pkg.sv ***
// Constants, register map and field layout of the input pattern event trigger.
// Assumes one 40 MHz clock, a synchronous active-low reset and an AXI4-Lite master.
package evt_trig_pkg;

  // Term layout: input points in the low bits, counter done levels above them.
  localparam int NUM_POINTS = 6;
  localparam int NUM_COUNTERS = 2;
  localparam int NUM_TERMS = NUM_POINTS + NUM_COUNTERS;
  localparam int POINT_LSB = 0;
  localparam int COUNTER_LSB = NUM_POINTS;

  // Event queue depth and width of the queued count.
  localparam int QUEUE_DEPTH = 4;
  localparam int COUNT_W = 3;
  localparam int SEQ_W = 32;
  localparam logic [31:0] SEQ_MAX = 32'hFFFF_FFFF;
  localparam logic [31:0] SEQ_FIRST = 32'h0000_0001;

  // Register byte addresses.
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SELECT = 8'h04;
  localparam logic [7:0] ADDR_LEVEL = 8'h08;
  localparam logic [7:0] ADDR_ACK = 8'h0C;
  localparam logic [7:0] ADDR_EVSTAT = 8'h10;
  localparam logic [7:0] ADDR_SEQ = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;
  localparam logic [7:0] ADDR_INPUTS = 8'h20;

  // Control register fields.
  localparam int CTRL_W = 6;
  localparam int CTRL_ACTIVE = 0;
  localparam int CTRL_ON_MATCH = 1;
  localparam int CTRL_ON_UNMATCH = 2;
  localparam int CTRL_HOLD = 3;
  localparam int CTRL_CLEAR = 4;
  localparam int CTRL_ANY_TERM = 5;

  // Event status register fields.
  localparam int EVS_RISE = 0;
  localparam int EVS_FALL = 1;
  localparam int EVS_DROPPED = 2;
  localparam int EVS_COUNT_LSB = 8;

  // Interrupt status and mask fields.
  localparam int IRQ_W = 2;
  localparam int IRQ_EVENT = 0;
  localparam int IRQ_DROP = 1;

  // Input readback: match state sits above the term levels.
  localparam int INPUTS_MATCH = 8;

  // Values after reset.
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [7:0] SELECT_RESET = 8'h00;
  localparam logic [7:0] LEVEL_RESET = 8'h00;
  localparam logic [31:0] ACK_RESET = 32'h0000_0000;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

// *** core/pin_sync.sv ***
// Three-stage synchroniser for asynchronous input levels.
// Assumes the inputs are pins with no relation to aclk.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic aclk, // System clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [WIDTH-1:0] async_in, // Raw pin levels.
  output logic [WIDTH-1:0] sync_out // Filtered levels.
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] out;
  } sync_state_t;

  sync_state_t q;
  sync_state_t n;

  // A new level counts only once the second and third stage agree, so a
  // metastable first stage never reaches the output directly.
  always_comb begin
    n = q;
    n.s1 = async_in;
    n.s2 = q.s1;
    n.s3 = q.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        n.out[i] = q.s3[i];
      end
    end
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign sync_out = q.out;

endmodule // pin_sync

// *** core/evt_trig.sv ***
// Input pattern event trigger with an AXI4-Lite register slave.
// Assumes one clock aclk, synchronous active-low reset, and asynchronous pin inputs.
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module evt_trig (
  input wire logic aclk, // System clock, 40 MHz.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [5:0] point_in, // Input point levels, asynchronous.
  input wire logic [1:0] counter_done_in, // Counter done levels, asynchronous.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [7:0] s_axi_awaddr, // Write byte address.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte enables.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  output logic [1:0] s_axi_bresp, // Write response code.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  input wire logic [7:0] s_axi_araddr, // Read byte address.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response code.
  output logic irq // Level interrupt, high while an unmasked status bit is set.
);

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [5:0] ctrl;
    logic [7:0] sel;
    logic [7:0] lvl;
    logic [31:0] ack;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic irq;
    logic clr_prev;
    logic match_prev;
    logic [31:0] seq;
    logic [31:0] rep_seq;
    logic rep_rise;
    logic rep_fall;
    logic dropped;
    logic [2:0] count;
    logic [3:0][31:0] qseq;
  } state_t;

  state_t q;
  state_t n;
  logic [7:0] terms;
  logic [7:0] term_ok;
  logic match;
  logic clr_edge;
  logic fire;
  logic fire_rise;
  logic head_acked;
  logic accept;
  logic drop;
  logic [31:0] seq_next;
  logic [31:0] ack_gap;
  logic [31:0] rd_word;

  // Pin levels are brought onto aclk before any comparison sees them.
  pin_sync #(
    .WIDTH(evt_trig_pkg::NUM_TERMS)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({counter_done_in, point_in}),
    .sync_out(terms)
  );

  // Byte-lane merge of a write onto an old register value.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = data[8*b +: 8];
      end
    end
    return r;
  endfunction

  // A term is met when selected and its level equals the programmed level.
  // Points and counters share one compare: level 1 asks for an active input.
  always_comb begin
    term_ok = q.sel & ~(terms ^ q.lvl);
    if (q.ctrl[evt_trig_pkg::CTRL_ANY_TERM]) begin
      match = |term_ok;
    end else begin
      match = (|q.sel) && ((term_ok | ~q.sel) == 8'hFF);
    end
  end

  // Edge of the match state; an unselected pattern never matches, so it fires only on unmatch, in the first cycle after its select is cleared.
  assign clr_edge = q.ctrl[evt_trig_pkg::CTRL_CLEAR] && !q.clr_prev;
  assign fire_rise = q.ctrl[evt_trig_pkg::CTRL_ON_MATCH] && match && !q.match_prev;
  assign fire = q.ctrl[evt_trig_pkg::CTRL_ACTIVE] &&
                (fire_rise || (q.ctrl[evt_trig_pkg::CTRL_ON_UNMATCH] && !match &&
                 q.match_prev));
  // Wrap-aware: head is acknowledged when it is not ahead of the ack value.
  assign ack_gap = q.ack - q.qseq[0];
  assign head_acked = (q.count != 3'h0) && !ack_gap[31];
  assign seq_next = (q.seq == evt_trig_pkg::SEQ_MAX) ? evt_trig_pkg::SEQ_FIRST :
                    q.seq + 32'h0000_0001;

  // Read decode of the register map.
  always_comb begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      evt_trig_pkg::ADDR_CTRL: rd_word[5:0] = q.ctrl;
      evt_trig_pkg::ADDR_SELECT: rd_word[7:0] = q.sel;
      evt_trig_pkg::ADDR_LEVEL: rd_word[7:0] = q.lvl;
      evt_trig_pkg::ADDR_ACK: rd_word = q.ack;
      evt_trig_pkg::ADDR_EVSTAT: begin
        rd_word[evt_trig_pkg::EVS_RISE] = q.rep_rise;
        rd_word[evt_trig_pkg::EVS_FALL] = q.rep_fall;
        rd_word[evt_trig_pkg::EVS_DROPPED] = q.dropped;
        rd_word[evt_trig_pkg::EVS_COUNT_LSB +: 3] = q.count;
      end
      evt_trig_pkg::ADDR_SEQ: rd_word = q.rep_seq;
      evt_trig_pkg::ADDR_IRQ_STAT: rd_word[1:0] = q.irq_stat;
      evt_trig_pkg::ADDR_IRQ_MASK: rd_word[1:0] = q.irq_mask;
      evt_trig_pkg::ADDR_INPUTS: begin
        rd_word[7:0] = terms;
        rd_word[evt_trig_pkg::INPUTS_MATCH] = match;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Next state: bus slave, event queue and interrupt bookkeeping.
  always_comb begin
    logic [1:0] w1c;
    logic [1:0] irq_set;
    logic [31:0] wv;
    logic hit;
    w1c = 2'h0;
    irq_set = 2'h0;
    wv = 32'h0000_0000;
    hit = 1'b0;
    accept = 1'b0;
    drop = 1'b0;
    n = q;

    // Write address and data are taken in either order.
    if (s_axi_awvalid && q.awready) begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    // Both halves present: commit the write and post its response.
    if (q.aw_got && q.w_got && !q.bvalid) begin
      hit = 1'b1;
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = evt_trig_pkg::RESP_OKAY;
      case (q.awaddr)
        evt_trig_pkg::ADDR_CTRL: begin
          wv = merge({26'h0, q.ctrl}, q.wdata, q.wstrb);
          n.ctrl = wv[5:0];
        end
        evt_trig_pkg::ADDR_SELECT: begin
          wv = merge({24'h0, q.sel}, q.wdata, q.wstrb);
          n.sel = wv[7:0];
        end
        evt_trig_pkg::ADDR_LEVEL: begin
          wv = merge({24'h0, q.lvl}, q.wdata, q.wstrb);
          n.lvl = wv[7:0];
        end
        evt_trig_pkg::ADDR_ACK: n.ack = merge(q.ack, q.wdata, q.wstrb);
        evt_trig_pkg::ADDR_IRQ_STAT: begin
          if (q.wstrb[0]) begin
            w1c = q.wdata[1:0];
          end
        end
        evt_trig_pkg::ADDR_IRQ_MASK: begin
          if (q.wstrb[0]) begin
            n.irq_mask = q.wdata[1:0];
          end
        end
        evt_trig_pkg::ADDR_EVSTAT, evt_trig_pkg::ADDR_SEQ, evt_trig_pkg::ADDR_INPUTS: begin
          hit = 1'b1;
        end
        default: n.bresp = evt_trig_pkg::RESP_DECERR;
      endcase
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;

    // Reads: one outstanding, data latched at the address handshake.
    if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      n.rvalid = 1'b1;
      n.rdata = rd_word;
      case (s_axi_araddr)
        evt_trig_pkg::ADDR_CTRL, evt_trig_pkg::ADDR_SELECT, evt_trig_pkg::ADDR_LEVEL,
        evt_trig_pkg::ADDR_ACK, evt_trig_pkg::ADDR_EVSTAT, evt_trig_pkg::ADDR_SEQ,
        evt_trig_pkg::ADDR_IRQ_STAT, evt_trig_pkg::ADDR_IRQ_MASK,
        evt_trig_pkg::ADDR_INPUTS: n.rresp = evt_trig_pkg::RESP_OKAY;
        default: n.rresp = evt_trig_pkg::RESP_DECERR;
      endcase
    end
    n.arready = !n.rvalid;

    // Match history follows the pattern even while inactive, so enabling a
    // definition on an already satisfied pattern does not fire by itself.
    n.clr_prev = q.ctrl[evt_trig_pkg::CTRL_CLEAR];
    n.match_prev = match;

    if (clr_edge) begin
      // The clear edge wins over any event of the same cycle.
      n.count = 3'h0;
      n.dropped = 1'b0;
      n.rep_rise = 1'b0;
      n.rep_fall = 1'b0;
      n.rep_seq = 32'h0000_0000;
    end else begin
      // Retire one acknowledged entry per cycle from the oldest end.
      if (head_acked) begin
        for (int i = 0; i < evt_trig_pkg::QUEUE_DEPTH - 1; i++) begin
          n.qseq[i] = q.qseq[i+1];
        end
        n.count = q.count - 3'h1;
      end
      if (fire) begin
        if (q.ctrl[evt_trig_pkg::CTRL_HOLD] && n.count != 3'h0) begin
          drop = 1'b1;
        end else begin
          accept = 1'b1;
          // A full queue loses its oldest entry; the newest is reported.
          if (n.count == 3'(evt_trig_pkg::QUEUE_DEPTH)) begin
            for (int i = 0; i < evt_trig_pkg::QUEUE_DEPTH - 1; i++) begin
              n.qseq[i] = n.qseq[i+1];
            end
            n.qseq[evt_trig_pkg::QUEUE_DEPTH-1] = seq_next;
            drop = 1'b1;
          end else begin
            n.qseq[n.count[1:0]] = seq_next;
            n.count = n.count + 3'h1;
          end
          n.seq = seq_next;
          n.rep_seq = seq_next;
          n.rep_rise = match;
          n.rep_fall = !match;
        end
        if (drop) begin
          n.dropped = 1'b1;
        end
      end
    end

    // Sticky interrupt status: a set in the same cycle beats the clear.
    irq_set[evt_trig_pkg::IRQ_EVENT] = accept;
    irq_set[evt_trig_pkg::IRQ_DROP] = drop;
    n.irq_stat = (q.irq_stat & ~w1c) | irq_set;
    n.irq = |(n.irq_stat & n.irq_mask);
    if (!hit) begin
      wv = 32'h0000_0000;
    end
  end

  // State register; every field has a defined value after reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.ctrl <= evt_trig_pkg::CTRL_RESET;
      q.sel <= evt_trig_pkg::SELECT_RESET;
      q.lvl <= evt_trig_pkg::LEVEL_RESET;
      q.ack <= evt_trig_pkg::ACK_RESET;
      q.irq_mask <= evt_trig_pkg::IRQ_MASK_RESET;
    end else begin
      q <= n;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign irq = q.irq;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_inactive_no_seq: assert property (
    !q.ctrl[evt_trig_pkg::CTRL_ACTIVE] |=> q.seq == $past(q.seq))
    else $error("sequence advanced while definition inactive");

  a_match_rise_event: assert property (
    q.ctrl[0] && q.ctrl[1] && match && !q.match_prev && !clr_edge && !q.ctrl[3]
    |=> q.rep_rise && !q.rep_fall && q.seq != $past(q.seq))
    else $error("newly matched pattern did not raise an event");

  a_unmatch_event: assert property (
    q.ctrl[0] && q.ctrl[2] && !match && q.match_prev && !clr_edge && !q.ctrl[3]
    |=> q.rep_fall && !q.rep_rise)
    else $error("lost match did not raise a fall event");

  a_hold_discards: assert property (
    q.ctrl[3] && fire && !clr_edge && q.count != 3'h0 && !head_acked
    |=> q.dropped && q.count == $past(q.count) && q.rep_seq == $past(q.rep_seq))
    else $error("held event was overwritten");

  a_clear_edge: assert property (
    $rose(q.ctrl[evt_trig_pkg::CTRL_CLEAR]) |-> ##1 q.count == 3'h0 && !q.dropped)
    else $error("clear edge did not empty the queue");

  a_any_vs_all: assert property (
    !q.ctrl[5] && match |-> ((terms ^ q.lvl) & q.sel) == 8'h00 && q.sel != 8'h00)
    else $error("all-terms mode matched with an unmet term");

  a_no_select_quiet: assert property (
    q.sel == 8'h00 |-> !match)
    else $error("pattern matched with no term selected");

  a_seq_wrap: assert property (
    accept && q.seq == evt_trig_pkg::SEQ_MAX |=> q.seq == evt_trig_pkg::SEQ_FIRST)
    else $error("sequence did not wrap to one");

  a_ack_drains: assert property (
    q.count != 3'h0 && q.ack == q.rep_seq && !fire && !q.ctrl[4]
    |-> ##[1:4] q.count == 3'h0)
    else $error("cumulative acknowledge did not drain the queue");

  // A software clear may drop a pending status, but a same-cycle set must survive it.
  a_irq_level: assert property (
    accept && n.irq_mask[evt_trig_pkg::IRQ_EVENT] |=> irq)
    else $error("accepted unmasked event did not raise the interrupt");

endmodule // evt_trig

// *** test/pin_source.sv ***
// Far-side source of the input point and counter done levels.
// Assumes the bench asks for a pattern on pin_req, changed just after a rising edge.
`timescale 1ns/1ps
module pin_source (
  input wire logic aclk, // System clock.
  input wire logic [7:0] pin_req, // Wanted levels, counters in the top two bits.
  output logic [5:0] point_in, // Input point levels.
  output logic [1:0] counter_done_in // Counter done levels.
);
  logic slow = 1'b0;

  // Pins follow a request at once or two edges late, in turn, since field
  // devices settle at their own pace.
  initial begin
    {counter_done_in, point_in} = 8'h00;
    forever begin
      @(posedge aclk);
      if (pin_req !== {counter_done_in, point_in}) begin
        if (slow) begin
          repeat (2) @(posedge aclk);
        end
        slow = ~slow;
        {counter_done_in, point_in} <= pin_req;
      end
    end
  end
endmodule // pin_source

// *** test/tb_evt_trig.sv ***
// Self-checking bench for the event trigger, against a queue-based model.
// Assumes the design package and a pin_source model of the field side.
`timescale 1ns/1ps
module tb_evt_trig;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic awr, wrdy, bv, arr, rv, irq;
  logic [7:0] awa = 8'h00, ara = 8'h00, pin_req = 8'h00;
  logic [31:0] wd = 32'h0000_0000, rd, d;
  logic [1:0] br, rr, cds;
  logic [5:0] pts;
  int seed = 37094, mismatches = 0, comparisons = 0;
  logic [31:0] q[$];
  logic [31:0] nseq = 32'h0000_0000, rseq = 32'h0000_0000;
  logic [7:0] ctrl = 8'h00, sel = 8'h00, lvl = 8'h00;
  logic [1:0] istat = 2'h0, imask = 2'h0;
  logic prev = 1'b0, clr_prev = 1'b0, rise = 1'b0, fall = 1'b0, drop = 1'b0;
  localparam logic [1:0] OK = evt_trig_pkg::RESP_OKAY;
  localparam logic [7:0] RA [5] = '{evt_trig_pkg::ADDR_CTRL, evt_trig_pkg::ADDR_SELECT,
    evt_trig_pkg::ADDR_LEVEL, evt_trig_pkg::ADDR_ACK, evt_trig_pkg::ADDR_IRQ_MASK};

  // Free-running 40 MHz clock.
  always #12.5 aclk = ~aclk;

  evt_trig dut_u (.aclk(aclk), .aresetn(aresetn), .point_in(pts), .counter_done_in(cds),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .irq(irq));

  pin_source far_u (.aclk(aclk), .pin_req(pin_req), .point_in(pts), .counter_done_in(cds));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Write and read hold each channel until its own handshake edge.
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (!ad && awr === 1'b1) begin
        ad = 1'b1;
        awv <= 1'b0;
      end
      if (!dd && wrdy === 1'b1) begin
        dd = 1'b1;
        wv <= 1'b0;
      end
    end
    do @(posedge aclk); while (bv !== 1'b1);
    chk(br, er);
    bry <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do @(posedge aclk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge aclk); while (rv !== 1'b1);
    v = rd;
    chk(rr, er);
    rry <= 1'b0;
    @(posedge aclk);
  endtask

  function automatic logic m_match();
    logic [7:0] met;
    met = ~(pin_req ^ lvl) & sel;
    return ctrl[5] ? (met != 8'h00) : (sel != 8'h00 && met == sel);
  endfunction

  // Model step: one clear edge or one pattern change since the last step.
  task automatic eval();
    logic m;
    m = m_match();
    if (ctrl[4] && !clr_prev) begin
      q.delete();
      {drop, rise, fall, rseq} = '0;
    end else if (ctrl[0] && m != prev && (m ? ctrl[1] : ctrl[2])) begin
      if (ctrl[3] && q.size() != 0) begin
        drop = 1'b1;
        istat = istat | 2'h2;
      end else begin
        if (q.size() == evt_trig_pkg::QUEUE_DEPTH) begin
          void'(q.pop_front());
          drop = 1'b1;
          istat = istat | 2'h2;
        end
        nseq = (nseq == 32'hFFFF_FFFF) ? 32'h0000_0001 : nseq + 32'h0000_0001;
        q.push_back(nseq);
        {rise, fall, rseq} = {m, !m, nseq};
        istat = istat | 2'h1;
      end
    end
    clr_prev = ctrl[4];
    prev = m;
  endtask

  task automatic check_all();
    rd_reg(evt_trig_pkg::ADDR_EVSTAT, d, OK);
    chk(d[1:0], {fall, rise});
    chk(d[2], drop);
    chk(d[10:8], q.size());
    rd_reg(evt_trig_pkg::ADDR_SEQ, d, OK);
    chk(d, rseq);
    rd_reg(evt_trig_pkg::ADDR_IRQ_STAT, d, OK);
    chk(d[1:0], istat);
    chk(irq, |(istat & imask));
  endtask

  task automatic cfg(input logic [7:0] a, input logic [31:0] v);
    wr_reg(a, v, OK);
    if (a == evt_trig_pkg::ADDR_CTRL) ctrl = v[7:0];
    if (a == evt_trig_pkg::ADDR_SELECT) sel = v[7:0];
    if (a == evt_trig_pkg::ADDR_LEVEL) lvl = v[7:0];
    if (a == evt_trig_pkg::ADDR_IRQ_MASK) imask = v[1:0];
    if (a == evt_trig_pkg::ADDR_IRQ_STAT) istat = istat & ~v[1:0];
    repeat (6) @(posedge aclk);
    eval();
    check_all();
  endtask

  // The sync chain and event register need well under twelve cycles.
  task automatic set_pins(input logic [7:0] v);
    pin_req <= v;
    repeat (12) @(posedge aclk);
    eval();
    check_all();
  endtask

  task automatic ack(input logic [31:0] v);
    wr_reg(evt_trig_pkg::ADDR_ACK, v, OK);
    repeat (6) @(posedge aclk);
    while (q.size() != 0 && $signed(v - q[0]) >= 0) void'(q.pop_front());
    check_all();
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard, far beyond the roughly one thousand cycles the tests need.
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    end_sim();
  end

  // Main sequence.
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (RA[i]) begin
      rd_reg(RA[i], d, OK);
      chk(d, 32'h0000_0000);
    end
    rd_reg(8'h24, d, evt_trig_pkg::RESP_DECERR);
    chk(d, 32'h0000_0000);
    wr_reg(8'h24, 32'hFFFF_FFFF, evt_trig_pkg::RESP_DECERR);
    wr_reg(evt_trig_pkg::ADDR_SEQ, 32'h0000_00FF, OK);
    check_all();
    $display("test registers done");
    cfg(evt_trig_pkg::ADDR_CTRL, 32'h0000_0007);
    repeat (3) set_pins(8'($random(seed)));
    cfg(evt_trig_pkg::ADDR_CTRL, 32'h0000_0027);
    repeat (3) set_pins(8'($random(seed)));
    cfg(evt_trig_pkg::ADDR_CTRL, 32'h0000_0007);
    $display("test no terms done");
    cfg(evt_trig_pkg::ADDR_SELECT, 32'h0000_0043);
    cfg(evt_trig_pkg::ADDR_LEVEL, 32'h0000_0041);
    set_pins(8'h45);
    set_pins(8'h47);
    repeat (6) set_pins(8'($random(seed)));
    cfg(evt_trig_pkg::ADDR_IRQ_MASK, 32'h0000_0003);
    cfg(evt_trig_pkg::ADDR_IRQ_STAT, 32'h0000_0003);
    ack(nseq);
    $display("test all terms done");
    cfg(evt_trig_pkg::ADDR_CTRL, 32'h0000_0027);
    repeat (6) set_pins(8'($random(seed)));
    for (int i = 0; i < 7; i++) set_pins(i[0] ? 8'h00 : 8'h02);
    ack(nseq - 32'h0000_0002);
    ack(nseq);
    $display("test any term done");
    cfg(evt_trig_pkg::ADDR_CTRL, 32'h0000_0037);
    set_pins(pin_req ^ 8'h02);
    cfg(evt_trig_pkg::ADDR_CTRL, 32'h0000_0037);
    cfg(evt_trig_pkg::ADDR_CTRL, 32'h0000_0027);
    ack(nseq);
    $display("test clear done");
    cfg(evt_trig_pkg::ADDR_CTRL, 32'h0000_002F);
    set_pins(pin_req ^ 8'h02);
    set_pins(pin_req ^ 8'h02);
    $display("test hold done");
    cfg(evt_trig_pkg::ADDR_CTRL, 32'h0000_0026);
    set_pins(pin_req ^ 8'h02);
    set_pins(pin_req ^ 8'h02);
    $display("test inactive done");
    end_sim();
  end
endmodule // tb_evt_trig
